// *** verilog/tsr_regs.sv ***
// status word and conversion result registers of a resistive touch controller
// How it works
// [R01] storing a type's data sets its ready flag
// [R02] flag clears once all updated registers read
// [R03] single current conversion flags D15/D14 only
// [R04] D7 low when reset since last status read
// [R05] D2 mirrors bias power-down select, resets 1
// [R06] 0 keeps bias on, 1 powers down
// [R07] bias always down between conversion sets
// [R08] select taken only on touch or start
// [R09] all result registers clear on reset
// [R10] value right-justified in D11-D0, rest zero
// [R11] 10-bit mode forces top two bits zero
// [R12] single current result D15 carries touch
// [R13] status word at index 8h, flag order
// [R14] status read sets reset indication back
//
// Decided for this implementation: the APB register port and the register addresses other than the status index 8h.
module tsr_regs #(
  parameter int NUM_RES = tsr_pkg::NUM_RES
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          soft_reset,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [tsr_pkg::ADDR_W+1:0]    paddr,
  input  wire logic [tsr_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [tsr_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          result_valid,
  input  wire tsr_pkg::tsr_result_type       result_in,
  input  wire logic                          pen_touch,
  input  wire logic                          conv_start,
  input  wire logic                          in_conversion,
  input  wire logic                          set_active,
  output logic                               bias_on,
  output logic                               ten_bit_mode,
  output logic                               irq
);
  localparam int RW = tsr_pkg::RES_W;
  localparam int NT = tsr_pkg::NUM_TYPES;

  logic [RW-1:0]      result_reg [NUM_RES];
  logic [NUM_RES-1:0] unread_reg;
  logic [NT-1:0]      ready_flags;
  logic               no_reset_reg;
  logic               pd_status_reg;
  logic [1:0]         ctrl_reg;
  logic [NT-1:0]      irq_sts_reg;
  logic [NT-1:0]      irq_msk_reg;
  logic [NT-1:0]      ready_prev_reg;
  logic               pen_s1_reg;
  logic               pen_s2_reg;
  logic [tsr_pkg::ADDR_W-1:0] idx;
  logic               access;
  logic               rd_en;
  logic               wr_en;
  logic               rd_status;
  logic               rd_result;
  logic [NUM_RES-1:0] rd_slot;
  logic [NUM_RES-1:0] wr_slot;
  logic               ctrl_wr;
  logic               msk_wr;
  logic               irq_rd;
  logic [RW-1:0]      status_word;
  logic               mapped;
  logic [NT-1:0]      rose;
  // decode selects and sampling strobes
  logic               sel_status;
  logic               sel_irq_sts;
  logic               sel_irq_msk;
  logic               sel_ctrl;
  logic               writable;
  logic               pd_take;

  // map result slots to their ready-flag type
  function automatic logic [NT-1:0] slot_types(input logic [NUM_RES-1:0] s);
    logic [NT-1:0] t;
    t = '0;
    t[tsr_pkg::TYPE_X]   = s[tsr_pkg::SLOT_X1] | s[tsr_pkg::SLOT_X2] | s[tsr_pkg::SLOT_IX];
    t[tsr_pkg::TYPE_Y]   = s[tsr_pkg::SLOT_Y1] | s[tsr_pkg::SLOT_Y2] | s[tsr_pkg::SLOT_IY];
    t[tsr_pkg::TYPE_Z1]  = s[tsr_pkg::SLOT_Z1];
    t[tsr_pkg::TYPE_Z2]  = s[tsr_pkg::SLOT_Z2];
    t[tsr_pkg::TYPE_AUX] = s[tsr_pkg::SLOT_AUX];
    return t;
  endfunction

  // format a raw value as a result word
  function automatic logic [RW-1:0] fmt(input tsr_pkg::tsr_result_type r,
                                        input logic tenb);
    logic [RW-1:0] w;
    w = '0;
    w[tsr_pkg::VAL_W-1:0] = r.value; // R10
    if (tenb) begin
      w[tsr_pkg::RES_TOP_BIT] = 1'b0; // R11
      w[tsr_pkg::RES_NEXT_BIT] = 1'b0; // R11
    end
    if (r.single_current) begin
      w[tsr_pkg::RES_TOUCH_BIT] = r.touched; // R12
    end
    return w;
  endfunction

  // true for word indexes inside the result window
  function automatic logic in_results(input logic [tsr_pkg::ADDR_W-1:0] a);
    logic lo_ok;
    logic hi_ok;
    lo_ok = a >= tsr_pkg::IDX_RES0;
    hi_ok = a < tsr_pkg::IDX_RES0 + tsr_pkg::ADDR_W'(NUM_RES);
    return lo_ok & hi_ok;
  endfunction

  // pen pin is asynchronous to the conversion clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pen_s1_reg <= 1'b0;
      pen_s2_reg <= 1'b0;
    end else begin
      pen_s1_reg <= pen_touch;
      pen_s2_reg <= pen_s1_reg;
    end
  end

  // apb decode; zero wait states, unmapped index answers pslverr
  assign idx    = paddr[tsr_pkg::ADDR_W+1:2];
  assign access = psel & penable;
  assign pready = 1'b1;
  assign rd_en  = access & ~pwrite;
  assign wr_en  = access & pwrite & pstrb[0];

  // one select per named word; the result window is decoded apart
  always_comb begin
    sel_status  = 1'b0;
    sel_irq_sts = 1'b0;
    sel_irq_msk = 1'b0;
    sel_ctrl    = 1'b0;
    case (idx)
      tsr_pkg::IDX_STATUS: begin
        sel_status = 1'b1; // R13
      end
      tsr_pkg::IDX_IRQ_STS: begin
        sel_irq_sts = 1'b1;
      end
      tsr_pkg::IDX_IRQ_MSK: begin
        sel_irq_msk = 1'b1;
      end
      tsr_pkg::IDX_CTRL: begin
        sel_ctrl = 1'b1;
      end
      default: begin
        sel_ctrl = 1'b0;
      end
    endcase
  end

  assign rd_status = rd_en & sel_status; // R13
  assign ctrl_wr   = wr_en & sel_ctrl;
  assign msk_wr    = wr_en & sel_irq_msk;
  assign irq_rd    = rd_en & sel_irq_sts;
  assign rd_result = in_results(idx);
  // only control and mask take writes
  assign writable  = sel_ctrl | sel_irq_msk;

  // per-slot read strobes clear the matching unread marks
  always_comb begin
    rd_slot = '0;
    for (int i = 0; i < NUM_RES; i++) begin
      rd_slot[i] = rd_en & (idx == tsr_pkg::IDX_RES0 + tsr_pkg::ADDR_W'(i));
    end
  end

  assign mapped = rd_result | sel_status | sel_irq_sts | sel_irq_msk | sel_ctrl;

  // read-only registers refuse writes with an error
  always_comb begin
    pslverr = 1'b0;
    if (access & ~mapped) begin
      pslverr = 1'b1;
    end else if (access & pwrite & ~writable) begin
      pslverr = 1'b1;
    end
  end

  // software-writable control: bias select and resolution
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= tsr_pkg::CTRL_RESET;
    end else if (soft_reset) begin
      ctrl_reg <= tsr_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg[tsr_pkg::CTRL_PD_BIT]  <= pwdata[tsr_pkg::CTRL_PD_BIT];
      ctrl_reg[tsr_pkg::CTRL_10B_BIT] <= pwdata[tsr_pkg::CTRL_10B_BIT];
    end
  end
  assign ten_bit_mode = ctrl_reg[tsr_pkg::CTRL_10B_BIT];

  // status mirror follows the select only at a clocked touch or start
  // a select written mid-set leaves the running set's bias plan alone until pen_s2_reg or conv_start is high
  assign pd_take = pen_s2_reg | conv_start; // R08
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_status_reg <= tsr_pkg::PD_RESET; // R05
    end else if (soft_reset) begin
      pd_status_reg <= tsr_pkg::PD_RESET; // R05
    end else if (pd_take) begin
      pd_status_reg <= ctrl_reg[tsr_pkg::CTRL_PD_BIT]; // R08
    end
  end

  // bias off between sets always; between conversions only when status is 1
  always_comb begin
    bias_on = 1'b0; // R07
    if (set_active) begin
      bias_on = in_conversion | ~pd_status_reg; // R06
    end
  end

  // result storage; a single current conversion only names its own slot
  always_comb begin
    wr_slot = '0;
    if (result_valid) begin
      wr_slot = result_in.slot_mask; // R03
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_RES; i++) begin
        result_reg[i] <= '0; // R09
      end
    end else if (soft_reset) begin
      for (int i = 0; i < NUM_RES; i++) begin
        result_reg[i] <= '0; // R09
      end
    end else begin
      for (int i = 0; i < NUM_RES; i++) begin
        if (wr_slot[i]) begin
          result_reg[i] <= fmt(result_in, ten_bit_mode); // R10
        end
      end
    end
  end

  // per-register unread marks; a new write beats a same-cycle read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unread_reg <= '0;
    end else if (soft_reset) begin
      unread_reg <= '0;
    end else begin
      // a slot rewritten in the cycle of its read stays unread
      for (int i = 0; i < NUM_RES; i++) begin
        if (wr_slot[i]) begin
          unread_reg[i] <= 1'b1; // R01
        end else if (rd_slot[i]) begin
          unread_reg[i] <= 1'b0; // R02
        end
      end
    end
  end
  assign ready_flags = slot_types(unread_reg); // R01 R02 R03

  // reset indication: low after any reset until the status is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      no_reset_reg <= 1'b0; // R04
    end else if (soft_reset) begin
      no_reset_reg <= 1'b0; // R04
    end else if (rd_status) begin
      no_reset_reg <= 1'b1; // R14
    end
  end

  always_comb begin
    status_word = '0;
    status_word[tsr_pkg::ST_READY_LSB +: NT] = ready_flags; // R13
    status_word[tsr_pkg::ST_RESET_BIT] = no_reset_reg; // R04
    status_word[tsr_pkg::ST_PD_BIT] = pd_status_reg; // R05
  end

  // interrupts: rising ready flags stick until the interrupt status word is read
  assign rose = ready_flags & ~ready_prev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_prev_reg <= '0;
    end else begin
      ready_prev_reg <= ready_flags;
    end
  end

  // a new event in the cycle of the clearing read wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_sts_reg <= '0;
    end else begin
      for (int i = 0; i < NT; i++) begin
        if (rose[i]) begin
          irq_sts_reg[i] <= 1'b1;
        end else if (irq_rd) begin
          irq_sts_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_msk_reg <= tsr_pkg::IRQ_MASK_RESET;
    end else if (msk_wr) begin
      irq_msk_reg <= pwdata[NT-1:0];
    end
  end
  // level output; masking hides an event but keeps it sticky
  always_comb begin
    irq = |(irq_sts_reg & irq_msk_reg);
  end

  // read data mux; combinational so the read and its side effect share an edge
  always_comb begin
    prdata = '0;
    if (rd_en) begin
      if (sel_status) begin
        prdata[RW-1:0] = status_word;
      end else if (sel_irq_sts) begin
        prdata[NT-1:0] = irq_sts_reg;
      end else if (sel_irq_msk) begin
        prdata[NT-1:0] = irq_msk_reg;
      end else if (sel_ctrl) begin
        prdata[1:0] = ctrl_reg;
      end else begin
        for (int i = 0; i < NUM_RES; i++) begin
          if (rd_slot[i]) begin
            prdata[RW-1:0] = result_reg[i];
          end
        end
      end
    end
  end
endmodule

// *** verilog/tsr_pkg.sv ***
// constants and carrier types of the touch status and result register bank
package tsr_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int RES_W  = 16;
  localparam int VAL_W  = 12;
  localparam int NUM_RES = 9;
  localparam int NUM_TYPES = 5;
  // word indexes; status index 8h as printed, results at indexes of our own
  localparam logic [ADDR_W-1:0] IDX_STATUS  = 12'h008;
  localparam logic [ADDR_W-1:0] IDX_RES0    = 12'h010;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STS = 12'h020;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MSK = 12'h021;
  localparam logic [ADDR_W-1:0] IDX_CTRL    = 12'h022;
  // result slots in index order
  localparam int SLOT_X1 = 0;
  localparam int SLOT_X2 = 1;
  localparam int SLOT_IX = 2;
  localparam int SLOT_Y1 = 3;
  localparam int SLOT_Y2 = 4;
  localparam int SLOT_IY = 5;
  localparam int SLOT_Z1 = 6;
  localparam int SLOT_Z2 = 7;
  localparam int SLOT_AUX = 8;
  // status word and result word field positions
  localparam int ST_READY_LSB = 11;
  localparam int ST_RESET_BIT = 7;
  localparam int ST_PD_BIT    = 2;
  localparam int RES_TOUCH_BIT = 15;
  localparam int RES_TOP_BIT   = 11;
  localparam int RES_NEXT_BIT  = 10;
  // ready-flag indexes: D15 down to D11
  localparam int TYPE_X   = 4;
  localparam int TYPE_Y   = 3;
  localparam int TYPE_Z1  = 2;
  localparam int TYPE_Z2  = 1;
  localparam int TYPE_AUX = 0;
  localparam logic       PD_RESET     = 1'b1;
  localparam logic [1:0] CTRL_RESET   = 2'h1;
  localparam int CTRL_PD_BIT   = 0;
  localparam int CTRL_10B_BIT  = 1;
  localparam logic [NUM_TYPES-1:0] IRQ_MASK_RESET = 5'h00;

  // one conversion result offered by the converter
  typedef struct packed {
    logic [NUM_RES-1:0] slot_mask;
    logic [VAL_W-1:0]   value;
    logic               single_current;
    logic               touched;
  } tsr_result_type;
endpackage

// *** tb/tsr_conv.sv ***
// converter model offering conversion results and start pulses
module tsr_conv (
  input  wire logic               clk,
  output logic                    result_valid,
  output tsr_pkg::tsr_result_type result_in,
  output logic                    conv_start
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    result_valid = 1'b0;
    result_in = '0;
    conv_start = 1'b0;
  end
  // data inverted after the pulse so a late sample never matches
  task automatic offer(input logic [8:0] m, input logic [11:0] v, input logic s, input logic t);
    @(posedge clk);
    result_valid <= 1'b1;
    result_in <= {m, v, s, t};
    @(posedge clk);
    result_valid <= 1'b0;
    result_in <= ~result_in;
  endtask
  task automatic start();
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
  endtask
endmodule

// *** tb/tsr_regs_checker.sv ***
// concurrent checks on the ports of the touch status and result registers
module tsr_regs_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        soft_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        in_conversion,
  input wire logic        set_active,
  input wire logic        bias_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] idx;
  logic        acc;
  logic        st_rd;
  logic        res;
  assign idx = paddr[13:2];
  assign acc = psel && penable;
  assign st_rd = acc && !pwrite && idx == tsr_pkg::IDX_STATUS;
  assign res = idx >= tsr_pkg::IDX_RES0 && idx <= tsr_pkg::IDX_RES0 + 12'h8;
  zero_wait_a: assert property (acc |-> pready) else $error("no pready");
  bias_off_a: assert property (!set_active |-> !bias_on)
    else $error("bias on between sets");
  bias_conv_a: assert property (set_active && in_conversion |-> bias_on)
    else $error("bias off in conversion");
  res_upper_a: assert property (acc && !pwrite && res |-> (prdata & 32'hFFFF7000) == 0)
    else $error("result upper bits set");
  status_rsv_a: assert property (st_rd |-> (prdata & 32'hFFFF077B) == 0)
    else $error("status reserved bits set");
  reset_flag_a: assert property ((st_rd && !soft_reset) ##1 (!soft_reset)[*2] ##1 st_rd
    |-> prdata[7]) else $error("reset flag not restored");
  ro_write_a: assert property (acc && pwrite && (res || idx == tsr_pkg::IDX_STATUS) |-> pslverr)
    else $error("read-only write accepted");
  unmapped_a: assert property (acc && !res && idx != tsr_pkg::IDX_STATUS
    && (idx < tsr_pkg::IDX_IRQ_STS || idx > tsr_pkg::IDX_CTRL) |-> pslverr && prdata == 0)
    else $error("unmapped access accepted");
  cover property (st_rd && prdata[15]);
  cover property (acc && !pwrite && res && prdata[15]);
  cover property (st_rd && !prdata[7]);
endmodule
bind tsr_regs tsr_regs_checker u_tsr_regs_checker (.*);

// *** tb/tsr_regs_tb_top.sv ***
// self-checking bench for the touch status and result registers
module tsr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] ST = tsr_pkg::IDX_STATUS;
  localparam logic [11:0] R0 = tsr_pkg::IDX_RES0;
  localparam logic [11:0] IS = tsr_pkg::IDX_IRQ_STS;
  logic                    clk, rst, soft_reset, psel, penable, pwrite, err, pready, pslverr;
  logic                    result_valid, conv_start, in_conversion, set_active, bias_on;
  logic                    ten_bit_mode, irq;
  logic                    pen_touch = 1'b0;
  logic [3:0]              pstrb = 4'hF;
  logic [13:0]             paddr;
  logic [31:0]             pwdata, prdata, rd;
  tsr_pkg::tsr_result_type result_in;
  int                      failures = 0;
  int                      tests_run = 0;
  tsr_regs u_tsr_regs (.*);
  tsr_conv u_tsr_conv (.*);
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    cmp(rd, exp);
    cmp({31'h0, err}, 32'h0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // whole run is under two hundred cycles
  initial begin
    #20000;
    failures++;
    give_verdict();
  end
  initial begin
    {rst, soft_reset, psel, penable, pwrite, in_conversion, set_active} = 7'h40;
    {paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rchk(ST, 32'h4);
    rchk(ST, 32'h84);
    for (int i = 0; i < 9; i++) begin
      rchk(R0 + 12'(i), 32'h0);
    end
    apb(1'b1, tsr_pkg::IDX_IRQ_MSK, 32'h1F);
    u_tsr_conv.offer(9'h3, 12'hABC, 1'b0, 1'b1);
    rchk(ST, 32'h8084);
    cmp({31'h0, irq}, 32'h1);
    rchk(R0, 32'hABC);
    rchk(ST, 32'h8084);
    rchk(R0 + 12'h1, 32'hABC);
    rchk(ST, 32'h84);
    rchk(IS, 32'h10);
    apb(1'b1, tsr_pkg::IDX_IRQ_MSK, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b1, tsr_pkg::IDX_CTRL, 32'h3);
    rchk(tsr_pkg::IDX_CTRL, 32'h3);
    cmp({31'h0, ten_bit_mode}, 32'h1);
    u_tsr_conv.offer(9'h100, 12'hFFF, 1'b0, 1'b1);
    rchk(ST, 32'h884);
    cmp({31'h0, irq}, 32'h0);
    rchk(R0 + 12'h8, 32'h3FF);
    rchk(IS, 32'h1);
    u_tsr_conv.offer(9'h20, 12'h123, 1'b1, 1'b1);
    rchk(ST, 32'h4084);
    rchk(R0 + 12'h5, 32'h8123);
    rchk(R0 + 12'h2, 32'h0);
    rchk(ST, 32'h84);
    apb(1'b1, tsr_pkg::IDX_CTRL, 32'h2);
    set_active <= 1'b1;
    rchk(ST, 32'h84);
    cmp({31'h0, bias_on}, 32'h0);
    u_tsr_conv.start();
    in_conversion <= 1'b1;
    rchk(ST, 32'h80);
    set_active <= 1'b0;
    apb(1'b1, ST, 32'hFFFF);
    cmp({31'h0, err}, 32'h1);
    cmp({31'h0, bias_on}, 32'h0);
    apb(1'b0, 12'hFF, 32'h0);
    cmp({err, rd[30:0]}, 32'h80000000);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rchk(ST, 32'h4);
    rchk(R0 + 12'h5, 32'h0);
    apb(1'b1, tsr_pkg::IDX_CTRL, 32'h0);
    rchk(ST, 32'h84);
    pen_touch <= 1'b1;
    repeat (3) @(posedge clk);
    pen_touch <= 1'b0;
    rchk(ST, 32'h80);
    give_verdict();
  end
endmodule
